// [pbsc_pkg.sv]
// Shared constants and carrier types for the pipelined burst memory control block
package pbsc_pkg;

    localparam int unsigned PBSC_ADDR_W     = 20;  // Word address width
    localparam int unsigned PBSC_LANES      = 4;   // Byte lanes per word
    localparam int unsigned PBSC_LANE_W     = 9;   // Eight data bits plus parity
    localparam int unsigned PBSC_DATA_W     = PBSC_LANES * PBSC_LANE_W;
    localparam int unsigned PBSC_BURST_W    = 2;   // Burst counter width
    localparam int unsigned PBSC_WAKE_CYC   = 2;   // Wake-up time in clock cycles
    localparam int unsigned PBSC_SYNC_DEPTH = 3;   // Flops on asynchronous pins
    localparam int unsigned PBSC_WBUF_DEPTH = 16;  // Write buffer depth in words

    // Write request travelling from the input register to the array
    typedef struct packed {
        logic [PBSC_ADDR_W-1:0] addr;
        logic [PBSC_DATA_W-1:0] data;
        logic [PBSC_LANES-1:0]  lanes;
    } pbsc_wreq_t;

    localparam int unsigned PBSC_WREQ_W = $bits(pbsc_wreq_t);

    // Bus cycle decoded on each edge
    typedef enum logic [2:0] {
        PBSC_OP_NONE,
        PBSC_OP_DESEL,
        PBSC_OP_START,
        PBSC_OP_CONT,
        PBSC_OP_SUSP
    } pbsc_op_t;

    // Power and burst state
    typedef enum logic [1:0] {
        PBSC_ST_IDLE,
        PBSC_ST_BURST,
        PBSC_ST_SLEEP,
        PBSC_ST_WAKE
    } pbsc_state_t;

endpackage : pbsc_pkg

// [pbsc_top.sv]
// Burst memory control block with write buffer, array and read pipeline
`timescale 1ns/1ns

// Synchronous FIFO; array storage, honest full and empty flags
module pbsc_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W:0]   count_r;
    logic             push;
    logic             pop;

    // Pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
        $error("pbsc_fifo depth must be a power of two of at least 2");
    end

    assign in_ready_o  = (count_r != (PTR_W+1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o  = mem[rd_ptr_r];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Storage has no reset; only the pointers and the count need a defined value
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data_i;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule : pbsc_fifo

module pbsc_top
    import pbsc_pkg::*;
#(
    parameter int unsigned ADDR_W     = PBSC_ADDR_W,
    parameter int unsigned WBUF_DEPTH = PBSC_WBUF_DEPTH
) (
    input  wire logic                   CLK_I,
    input  wire logic                   NRST_I,
    input  wire logic [ADDR_W-1:0]      ADDR_I,
    input  wire logic                   PROC_ADDR_STROBE_N_I,
    input  wire logic                   CTRL_ADDR_STROBE_N_I,
    input  wire logic                   BURST_ADVANCE_N_I,
    input  wire logic                   GLOBAL_WRITE_N_I,
    input  wire logic                   BYTE_WRITE_ENABLE_N_I,
    input  wire logic [PBSC_LANES-1:0]  LANE_WRITE_N_I,
    input  wire logic                   CHIP_SELECT_1_N_I,
    input  wire logic                   CHIP_SELECT_AUX_I,
    input  wire logic                   CHIP_SELECT_3_N_I,
    input  wire logic                   OUTPUT_ENABLE_N_I,
    input  wire logic                   BURST_ORDER_SELECT_I,
    input  wire logic                   SLEEP_REQUEST_I,
    input  wire logic [PBSC_DATA_W-1:0] DQ_I,
    output logic      [PBSC_DATA_W-1:0] DQ_O,
    output logic                        DQ_OE_O,
    output logic                        WBUF_READY_O,
    output logic                        SLEEPING_O
);
    localparam int unsigned BW = PBSC_BURST_W;

    // Carrier struct fixes the address width; the buffer needs two words at least
    if (ADDR_W != PBSC_ADDR_W || WBUF_DEPTH < 2) begin : g_bad_param
        $error("pbsc_top: address width must match the package, depth at least 2");
    end

    // Three-flop synchronisers for the asynchronous level pins
    logic [PBSC_SYNC_DEPTH-1:0] zz_sync_r;
    logic [PBSC_SYNC_DEPTH-1:0] lbo_sync_r;
    logic                       zz_lvl_r;
    logic                       lbo_lvl_r;

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            zz_sync_r  <= '0;
            lbo_sync_r <= '0;
        end else begin
            zz_sync_r  <= {zz_sync_r[PBSC_SYNC_DEPTH-2:0], SLEEP_REQUEST_I};
            lbo_sync_r <= {lbo_sync_r[PBSC_SYNC_DEPTH-2:0], BURST_ORDER_SELECT_I};
        end
    end

    // A change counts once the second and third stages agree
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            zz_lvl_r  <= 1'b0;
            lbo_lvl_r <= 1'b0;
        end else begin
            if (zz_sync_r[1] == zz_sync_r[2]) begin
                zz_lvl_r <= zz_sync_r[2];
            end
            if (lbo_sync_r[1] == lbo_sync_r[2]) begin
                lbo_lvl_r <= lbo_sync_r[2];
            end
        end
    end

    // Burst and power state
    pbsc_state_t          state_r;
    logic [1:0]           wake_cnt_r;
    logic [ADDR_W-1:BW]   addr_hi_r;
    logic [BW-1:0]        start_lo_r;
    logic [BW-1:0]        cnt_r;
    logic                 burst_wr_r;

    // Access issued on the previous edge and the read pipeline
    logic                 acc_rd_r;
    logic [ADDR_W-1:0]    acc_addr_r;
    logic                 s1_v_r;
    logic [PBSC_DATA_W-1:0] s1_data_r;
    logic                 buf_v_r;
    logic [PBSC_DATA_W-1:0] buf_r;
    logic                 wr_off_r;
    pbsc_wreq_t           wreq_r;
    logic                 wreq_v_r;

    logic [PBSC_DATA_W-1:0] mem [2**ADDR_W];

    // Edge decode signals
    logic                 awake;
    logic                 cs_ok;
    logic                 proc_go;
    logic                 ctrl_go;
    logic                 wr_qual;
    logic [PBSC_LANES-1:0] lane_mask;
    logic [BW-1:0]        cnt_step;
    logic [BW-1:0]        lo_cur;
    logic [BW-1:0]        lo_next;
    pbsc_op_t             op;
    logic                 op_wr;
    logic [ADDR_W-1:0]    op_addr;
    logic                 wbuf_in_ready;
    logic                 wbuf_out_valid;
    logic                 wbuf_out_ready;
    pbsc_wreq_t           wbuf_head;

    assign awake   = (state_r == PBSC_ST_IDLE) || (state_r == PBSC_ST_BURST);
    assign cs_ok   = !CHIP_SELECT_1_N_I && CHIP_SELECT_AUX_I && !CHIP_SELECT_3_N_I;
    assign proc_go = !PROC_ADDR_STROBE_N_I && !CHIP_SELECT_1_N_I;
    assign ctrl_go = PROC_ADDR_STROBE_N_I && !CTRL_ADDR_STROBE_N_I;

    // Global write forces every lane; otherwise byte enable gates lane strobes
    assign lane_mask = !GLOBAL_WRITE_N_I ? '1 :
                       (!BYTE_WRITE_ENABLE_N_I ? ~LANE_WRITE_N_I : '0);
    assign wr_qual   = |lane_mask;

    // Burst order: interleaved XOR or linear increment of the low bits
    assign cnt_step = cnt_r + 1'b1;
    assign lo_cur   = lbo_lvl_r ? (start_lo_r ^ cnt_r) : (start_lo_r + cnt_r);
    assign lo_next  = lbo_lvl_r ? (start_lo_r ^ cnt_step)
                                : (start_lo_r + cnt_step);

    // Decode the cycle sampled on this edge
    always_comb begin
        op      = PBSC_OP_NONE;
        op_wr   = 1'b0;
        op_addr = {addr_hi_r, lo_cur};
        if (awake && proc_go) begin
            op      = cs_ok ? PBSC_OP_START : PBSC_OP_DESEL;
            op_addr = ADDR_I;
            op_wr   = 1'b0;
        end else if (awake && ctrl_go) begin
            op      = cs_ok ? PBSC_OP_START : PBSC_OP_DESEL;
            op_addr = ADDR_I;
            op_wr   = wr_qual;
        end else if (state_r == PBSC_ST_BURST && !BURST_ADVANCE_N_I) begin
            op      = PBSC_OP_CONT;
            op_addr = {addr_hi_r, lo_next};
            op_wr   = wr_qual;
        end else if (state_r == PBSC_ST_BURST) begin
            op      = PBSC_OP_SUSP;
            op_wr   = wr_qual;
        end
    end

    // Power state, burst registers and wake-up count
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_r    <= PBSC_ST_IDLE;
            wake_cnt_r <= '0;
            addr_hi_r  <= '0;
            start_lo_r <= '0;
            cnt_r      <= '0;
            burst_wr_r <= 1'b0;
        end else begin
            unique case (state_r)
                PBSC_ST_IDLE,
                PBSC_ST_BURST: begin
                    if (zz_lvl_r) begin
                        state_r <= PBSC_ST_SLEEP;
                    end else if (op == PBSC_OP_START) begin
                        state_r    <= PBSC_ST_BURST;
                        addr_hi_r  <= ADDR_I[ADDR_W-1:BW];
                        start_lo_r <= ADDR_I[BW-1:0];
                        cnt_r      <= '0;
                        burst_wr_r <= op_wr;
                    end else if (op == PBSC_OP_DESEL) begin
                        state_r <= PBSC_ST_IDLE;
                    end else if (op == PBSC_OP_CONT) begin
                        cnt_r      <= cnt_step;                               // Wraps after four
                        burst_wr_r <= op_wr;
                    end
                end
                PBSC_ST_SLEEP: begin
                    if (!zz_lvl_r) begin
                        state_r    <= PBSC_ST_WAKE;
                        wake_cnt_r <= 2'(PBSC_WAKE_CYC - 1);
                    end
                end
                PBSC_ST_WAKE: begin
                    if (zz_lvl_r) begin
                        state_r <= PBSC_ST_SLEEP;
                    end else if (wake_cnt_r == '0) begin
                        state_r <= PBSC_ST_IDLE;                              // Burst registers kept; state returns to idle
                    end else begin
                        wake_cnt_r <= wake_cnt_r - 1'b1;
                    end
                end
            endcase
        end
    end

    // Access register: reads flow into the pipeline, writes to the buffer
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            acc_rd_r   <= 1'b0;
            acc_addr_r <= '0;
            wr_off_r   <= 1'b0;
        end else begin
            acc_rd_r   <= awake && !zz_lvl_r && !op_wr &&
                          (op == PBSC_OP_START || op == PBSC_OP_CONT || op == PBSC_OP_SUSP);
            acc_addr_r <= op_addr;
            wr_off_r   <= awake && op_wr;
        end
    end

    // Input data register; held while the buffer pushes back
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            wreq_v_r <= 1'b0;
            wreq_r   <= '0;
        end else if (!wreq_v_r || wbuf_in_ready) begin
            wreq_v_r     <= awake && !zz_lvl_r && op_wr && op != PBSC_OP_DESEL;
            wreq_r.addr  <= op_addr;
            wreq_r.data  <= DQ_I;
            wreq_r.lanes <= lane_mask;
        end
    end

    // Array write port is separate from the read port, so writes drain on every
    // awake cycle; a suspended read would otherwise stall the buffer for good
    assign wbuf_out_ready = awake;
    assign WBUF_READY_O   = !wreq_v_r || wbuf_in_ready;

    pbsc_fifo #(
        .WIDTH (PBSC_WREQ_W),
        .DEPTH (WBUF_DEPTH)
    ) u_wbuf (
        .clk_i       (CLK_I),
        .nrst_i      (NRST_I),
        .in_valid_i  (wreq_v_r),
        .in_ready_o  (wbuf_in_ready),
        .in_data_i   (wreq_r),
        .out_valid_o (wbuf_out_valid),
        .out_ready_i (wbuf_out_ready),
        .out_data_o  (wbuf_head)
    );

    // Self-timed array write, one byte lane per strobe
    always_ff @(posedge CLK_I) begin
        if (wbuf_out_valid && wbuf_out_ready) begin
            for (int l = 0; l < PBSC_LANES; l++) begin
                if (wbuf_head.lanes[l]) begin
                    mem[wbuf_head.addr][l*PBSC_LANE_W +: PBSC_LANE_W] <=
                        wbuf_head.data[l*PBSC_LANE_W +: PBSC_LANE_W];
                end
            end
        end
    end

    // Two read stages; a deselect clears both stages so drive drops on that edge
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            s1_v_r    <= 1'b0;
            s1_data_r <= '0;
            buf_v_r   <= 1'b0;
            buf_r     <= '0;
        end else if (awake) begin
            s1_v_r    <= acc_rd_r && op != PBSC_OP_DESEL;
            s1_data_r <= mem[acc_addr_r];
            buf_v_r   <= s1_v_r && op != PBSC_OP_DESEL;
            buf_r     <= s1_data_r;
        end else begin
            s1_v_r  <= 1'b0;                                                  // No stale drive on wake
            buf_v_r <= 1'b0;                                                  // Data kept
        end
    end

    // Output enable acts without the clock; limitation: pending writes
    // still in the buffer are not forwarded to reads of the same word
    assign DQ_O       = buf_r;
    assign DQ_OE_O    = buf_v_r && !OUTPUT_ENABLE_N_I && !wr_off_r && awake;
    assign SLEEPING_O = !awake;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    chk_sleep_hiz: assert property (!awake |-> !DQ_OE_O)
        else $error("data driven while asleep");
    chk_wake_delay: assert property ($fell(zz_lvl_r) && state_r == PBSC_ST_SLEEP
        |=> !awake ##1 !awake)
        else $error("woke before two cycles");
    chk_read_start: assert property (awake && !zz_lvl_r && op == PBSC_OP_START && !op_wr
        |=> acc_rd_r && acc_addr_r == $past(ADDR_I))
        else $error("read burst not started at external address");
    chk_pipe_depth: assert property (acc_rd_r && awake && op != PBSC_OP_DESEL
        ##1 awake && op != PBSC_OP_DESEL
        |=> buf_v_r && buf_r == $past(mem[acc_addr_r], 2))
        else $error("read data not two stages later");
    chk_hold_addr: assert property (awake && op == PBSC_OP_SUSP && !zz_lvl_r
        |=> $stable(cnt_r) && $stable(addr_hi_r))
        else $error("burst moved during wait state");
    chk_block_cs1: assert property (awake && !zz_lvl_r && CHIP_SELECT_1_N_I
        && !PROC_ADDR_STROBE_N_I && CTRL_ADDR_STROBE_N_I
        |=> $stable(state_r) && $stable(addr_hi_r) && $stable(start_lo_r))
        else $error("blocked strobe changed the burst");
    chk_wr_off: assert property (state_r == PBSC_ST_BURST && PROC_ADDR_STROBE_N_I
        && !BYTE_WRITE_ENABLE_N_I && !(&LANE_WRITE_N_I) |=> !DQ_OE_O)
        else $error("drivers on after lane write");
    chk_step: assert property (awake && !zz_lvl_r && op == PBSC_OP_CONT
        |=> cnt_r == $past(cnt_r) + 2'h1)
        else $error("burst counter did not step");
    chk_deselect: assert property (awake && op == PBSC_OP_DESEL
        ##1 awake |=> !buf_v_r)
        else $error("data driven after deselect");

    cov_read_burst: cover property (op == PBSC_OP_START ##1 op == PBSC_OP_CONT
        ##1 op == PBSC_OP_CONT ##1 op == PBSC_OP_CONT);
    cov_ctrl_write: cover property (ctrl_go && cs_ok && wr_qual && awake);
    cov_sleep_wake: cover property (state_r == PBSC_ST_WAKE ##1 state_r == PBSC_ST_IDLE);
    cov_wbuf_full: cover property (!wbuf_in_ready);

endmodule : pbsc_top

// [pbsc_ctrl_model.sv]
// Bus controller model that drives the memory control pins one cycle at a time
`timescale 1ns/1ns
module pbsc_ctrl_model
    import pbsc_pkg::*;
(
    input  wire logic                   clk_i,
    output logic      [PBSC_ADDR_W-1:0] addr_o,
    output logic                        proc_n_o,
    output logic                        ctrl_n_o,
    output logic                        adv_n_o,
    output logic                        gw_n_o,
    output logic                        bwe_n_o,
    output logic      [PBSC_LANES-1:0]  lane_n_o,
    output logic                        oe_n_o,
    output logic      [PBSC_DATA_W-1:0] dq_o
);
    // Quiet bus from time zero
    initial begin
        {proc_n_o, ctrl_n_o, adv_n_o, gw_n_o, bwe_n_o, oe_n_o} = 6'h3F;
        lane_n_o = 4'hF;
        addr_o   = '0;
        dq_o     = '0;
    end

    // One bus cycle, launched just after a rising edge and held for a whole cycle
    task automatic drv(input logic p, input logic c, input logic v, input logic g,
                       input logic [3:0] l, input logic [PBSC_ADDR_W-1:0] a,
                       input logic [PBSC_DATA_W-1:0] d);
        logic w;
        w = ~g | ~&l;
        @(posedge clk_i);
        proc_n_o <= p | ~c;  // Processor strobe held off on a controller start
        ctrl_n_o <= c;
        adv_n_o  <= v;
        gw_n_o   <= g;
        bwe_n_o  <= &l;
        lane_n_o <= l;
        addr_o   <= a;
        oe_n_o   <= w;  // Drivers turned off for every write
        // A released bus shows a changing pattern, never the last value
        dq_o     <= w ? d : ~dq_o;
    endtask : drv
endmodule : pbsc_ctrl_model

// [pbsc_top_bench.sv]
// Self-checking bench for the burst memory control block
`timescale 1ns/1ns
module pbsc_top_bench
    import pbsc_pkg::*;
;
    localparam logic [19:0] BASE  = 20'h0ABC4;
    localparam logic [35:0] LMASK = 36'h007FC01FF;
    logic                   clk   = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   cs1_n = 1'b0;
    logic                   cs_aux = 1'b1;
    logic                   order = 1'b0;
    logic                   sleep = 1'b0;
    logic [19:0]            addr;
    logic                   proc_n, ctrl_n, adv_n, gw_n, bwe_n, oe_n;
    logic [3:0]             lane_n;
    logic [35:0]            dq_in, dq_out;
    logic                   dq_oe, wbuf_rdy, sleeping;
    logic [3:0][35:0]       wd;
    int                     err_total = 0;
    int                     n_tests = 0;

    // Free-running 20 MHz clock
    always #25 clk = ~clk;

    pbsc_ctrl_model ctl_u (.clk_i(clk), .addr_o(addr), .proc_n_o(proc_n), .ctrl_n_o(ctrl_n),
        .adv_n_o(adv_n), .gw_n_o(gw_n), .bwe_n_o(bwe_n), .lane_n_o(lane_n), .oe_n_o(oe_n),
        .dq_o(dq_in));

    // Third select held active; chip select one and the auxiliary select are exercised
    pbsc_top dut_u (.CLK_I(clk), .NRST_I(rst_n), .ADDR_I(addr), .PROC_ADDR_STROBE_N_I(proc_n),
        .CTRL_ADDR_STROBE_N_I(ctrl_n), .BURST_ADVANCE_N_I(adv_n), .GLOBAL_WRITE_N_I(gw_n),
        .BYTE_WRITE_ENABLE_N_I(bwe_n), .LANE_WRITE_N_I(lane_n), .CHIP_SELECT_1_N_I(cs1_n),
        .CHIP_SELECT_AUX_I(cs_aux), .CHIP_SELECT_3_N_I(1'b0), .OUTPUT_ENABLE_N_I(oe_n),
        .BURST_ORDER_SELECT_I(order), .SLEEP_REQUEST_I(sleep), .DQ_I(dq_in), .DQ_O(dq_out),
        .DQ_OE_O(dq_oe), .WBUF_READY_O(wbuf_rdy), .SLEEPING_O(sleeping));

    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) ctl_u.drv(1'b1, 1'b1, 1'b1, 1'b1, 4'hF, '0, '0);
    endtask : idle

    // Four-beat write burst from a controller strobe, then a pause so the buffer drains
    task automatic wr(input logic g, input logic [3:0] l, input logic [3:0][35:0] d);
        ctl_u.drv(1'b1, 1'b0, 1'b1, g, l, BASE, d[0]);
        for (int k = 1; k < 4; k++) ctl_u.drv(1'b1, 1'b1, 1'b0, g, l, '0, d[k]);
        idle(10);
        #5;
        chk("wbuf ready", wbuf_rdy, 1'b1);
    endtask : wr

    // Processor-strobe read with s wait states; lane strobes and advance low on the start edge
    task automatic rd(input logic [19:0] a, input int s, input logic [3:0][35:0] e);
        int k;
        for (int j = 0; j < s + 7; j++) begin
            if (j == 0) ctl_u.drv(1'b0, 1'b1, 1'b0, 1'b1, 4'h0, a, '0);
            else ctl_u.drv(1'b1, 1'b1, !(j > s && j < s + 4), 1'b1, 4'hF, '0, '0);
            #5;
            k = (j - 3 - s < 0) ? 0 : j - 3 - s;
            if (j >= 3) chk("read word", dq_out, e[k]);
            if (j == 3) chk("drive enable", dq_oe, 1'b1);
        end
    endtask : rd

    // Global write, then linear and interleaved reads from an odd start
    task automatic t_order();
        logic [3:0][35:0] e;
        for (int k = 0; k < 4; k++) wd[k] = 36'h123456780 + 36'(k);
        wr(1'b0, 4'hF, wd);  // All lanes with lane strobes high
        for (int k = 0; k < 4; k++) e[k] = wd[(k + 1) % 4];
        rd(BASE + 20'h1, 0, e);
        idle(1);
        order <= 1'b1;
        idle(6);
        for (int k = 0; k < 4; k++) e[k] = wd[k ^ 1];
        rd(BASE + 20'h1, 0, e);
        idle(1);
        order <= 1'b0;
        idle(6);
    endtask : t_order

    // Two-lane write burst, read back with two wait states
    task automatic t_lanes();
        logic [3:0][35:0] e;
        wr(1'b1, 4'b1010, {4{36'hFFFFFFFFF}});  // Lanes 0 and 2 only
        for (int k = 0; k < 4; k++) e[k] = wd[k] | LMASK;
        rd(BASE, 2, e);  // Word held during wait states
        wd = e;
    endtask : t_lanes

    // Blocked processor strobe mid-burst, a deselect, then a start with the auxiliary select off
    task automatic t_desel();
        @(posedge clk);
        cs1_n <= 1'b1;
        ctl_u.drv(1'b0, 1'b1, 1'b1, 1'b1, 4'hF, BASE, '0);
        ctl_u.drv(1'b1, 1'b0, 1'b1, 1'b1, 4'hF, BASE, '0);
        #5;
        chk("blocked strobe", dq_oe, 1'b1);
        for (int j = 0; j < 5; j++) begin
            idle(1);
            #5;
            if (j > 0) chk("drive enable", dq_oe, 1'b0);
        end
        @(posedge clk);
        cs1_n  <= 1'b0;
        cs_aux <= 1'b0;
        ctl_u.drv(1'b0, 1'b1, 1'b1, 1'b1, 4'hF, BASE, '0);
        for (int j = 0; j < 4; j++) begin
            idle(1);
            #5;
            chk("aux deselect", dq_oe, 1'b0);
        end
        @(posedge clk);
        cs_aux <= 1'b1;
    endtask : t_desel

    // Sleep keeps the array; wake-up takes at least the wake time
    task automatic t_sleep();
        int n;
        idle(1);
        sleep <= 1'b1;
        idle(8);
        #5;
        chk("sleeping", sleeping, 1'b1);
        chk("drive enable", dq_oe, 1'b0);
        idle(1);
        sleep <= 1'b0;
        n = 0;
        while (sleeping !== 1'b0 && n < 20) begin
            idle(1);
            #5;
            n++;
        end
        chk("wake time", n >= 2 && n < 20, 1'b1);
        idle(2);  // Strobes held off after wake
        rd(BASE, 0, wd);
    endtask : t_sleep

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // Reset for eight cycles, then the scenarios in turn
    initial begin
        repeat (4) @(posedge clk);
        #5;
        chk("reset enable", dq_oe, 1'b0);
        chk("reset data", dq_out, '0);
        chk("reset sleeping", sleeping, 1'b0);
        chk("reset wbuf", wbuf_rdy, 1'b1);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_order();
        t_lanes();
        t_desel();
        t_sleep();
        give_verdict();
    end
endmodule : pbsc_top_bench
